// ---- eqasr_defines.svh ----
`ifndef EQASR_DEFINES_SVH
`define EQASR_DEFINES_SVH

// Shared register offsets
`define EQASR_OFS_STRAP_OBS    8'h00
`define EQASR_OFS_SOFT_RST     8'h04
`define EQASR_OFS_STRAP_EN     8'h06
`define EQASR_OFS_REVISION     8'hF0
`define EQASR_OFS_CHAN_CTRL    8'hFF

// Channel register offsets
`define EQASR_OFS_CDR_CTRL     8'h0A
`define EQASR_OFS_EYE_CFG      8'h11
`define EQASR_OFS_THRESH       8'h32
`define EQASR_OFS_INT_STATUS   8'h54
`define EQASR_OFS_INT_MASK     8'h56

// Reset values
`define EQASR_RST_STRAP_OBS    4'h0
`define EQASR_RST_SOFT_RST     8'h01
`define EQASR_RST_STRAP_EN     8'h00
`define EQASR_RST_CHAN_CTRL    8'h00
`define EQASR_RST_CDR_CTRL     8'h00
`define EQASR_RST_EYE_CFG      8'h20
`define EQASR_RST_THRESH       8'h00
`define EQASR_RST_INT_MASK     8'h00
// Arbitrary revision value
`define EQASR_REVISION_CODE    8'h5A

// Field positions
`define EQASR_BIT_SOFT_RST     6
`define EQASR_BIT_ROUTE_INT    5
`define EQASR_BIT_CHAN_SEL     2
`define EQASR_BIT_EYE_OFF      5
`define EQASR_CDR_RST_HI       3
`define EQASR_CDR_RST_LO       2
`define EQASR_INT_SIGDET       7
`define EQASR_INT_LOCK         6
`define EQASR_INT_EYE          3
`define EQASR_INT_LOCK_LOSS    2

// Strap observation opens above this test-control value
`define EQASR_STRAP_EN_MIN     4'h9
// Upper three bits of the management address; straps give the low four
`define EQASR_DEV_ADDR_HI      3'h5
`define EQASR_BYTE_LAST        4'h8

`endif

// ---- eqasr_host_model.sv ----
`timescale 1ns/1ps
module eqasr_host_model
(
    input  wire logic       clk_sys,
    input  wire logic [6:0] dev_addr,
    input  wire logic       sda_wire,
    output logic            scl_pin,
    output logic            sda_low
);
    int nack_cnt = 0;
    initial
    begin
        scl_pin = 1'h1;
        sda_low = 1'h0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Data only moves while the clock is low; a 1 is sent by releasing
    task automatic bits9(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--)
        begin
            sda_low <= ~tx[i];
            tick(4);
            scl_pin <= 1'h1;
            tick(4);
            rx[i] = sda_wire;
            tick(4);
            scl_pin <= 1'h0;
            tick(4);
        end
    endtask
    task automatic start();
        sda_low <= 1'h1;
        tick(8);
        scl_pin <= 1'h0;
        tick(4);
    endtask
    task automatic stop();
        sda_low <= 1'h1;
        tick(4);
        scl_pin <= 1'h1;
        tick(8);
        sda_low <= 1'h0;
        tick(8);
    endtask
    task automatic wr_reg(input logic [6:0] a, input logic [7:0] ofs,
                          input logic [7:0] data, input logic ptr_only);
        logic [8:0] r;
        start();
        bits9({a, 1'h0, 1'h1}, r);
        if (r[0] === 1'h0)
        begin
            bits9({ofs, 1'h1}, r);
            if (!ptr_only)
                bits9({data, 1'h1}, r);
        end
        else
            nack_cnt++;
        stop();
    endtask
    // Pointer set by a bare write, then one byte read and refused
    task automatic rd_reg(input logic [7:0] ofs, output logic [7:0] data);
        logic [8:0] r;
        wr_reg(dev_addr, ofs, 8'h00, 1'h1);
        start();
        bits9({dev_addr, 1'h1, 1'h1}, r);
        bits9({8'hFF, 1'h1}, r);
        data = r[8:1];
        stop();
    endtask
endmodule // eqasr_host_model

// ---- eqasr_mgmt_slave.sv ----
`timescale 1ns/1ps
`include "eqasr_defines.svh"

module eqasr_mgmt_slave
(
    input  wire logic               clk_sys,
    input  wire logic               reset,
    input  wire logic               scl_pin,
    input  wire logic               sda_in,
    input  wire logic [3:0]         strap_sync,
    input  wire eqasr_pkg::eqasr_byte_t rdata,
    output logic                    sda_oe,
    output eqasr_pkg::eqasr_byte_t  reg_addr,
    output eqasr_pkg::eqasr_byte_t  wdata,
    output logic                    wr_strobe,
    output logic                    rd_strobe
);
    import eqasr_pkg::*;

    logic [1:0]        scl_meta;
    logic [1:0]        sda_meta;
    logic              scl_d;
    logic              sda_d;
    eqasr_mgmt_state_t state;
    eqasr_byte_t       shreg;
    logic [3:0]        count;
    logic              rd_mode;
    logic              nacked;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_cond;
    logic              stop_cond;

    // Only the second and third stages feed any logic
    always_ff @(posedge clk_sys)
    begin
        scl_meta <= {scl_meta[0], scl_pin};
        sda_meta <= {sda_meta[0], sda_in};
        scl_d    <= scl_meta[1];
        sda_d    <= sda_meta[1];
    end

    assign scl_rise   = scl_meta[1] & ~scl_d;
    assign scl_fall   = ~scl_meta[1] & scl_d;
    assign start_cond = scl_meta[1] & scl_d & sda_d & ~sda_meta[1];
    assign stop_cond  = scl_meta[1] & scl_d & ~sda_d & sda_meta[1];

    always_ff @(posedge clk_sys)
    begin
        wr_strobe <= 1'b0;
        rd_strobe <= 1'b0;
        if (reset || stop_cond)
        begin
            state  <= EQASR_ST_IDLE;
            sda_oe <= 1'b0;
            count  <= 4'h0;
            if (reset)
            begin
                shreg    <= 8'h00;
                reg_addr <= 8'h00;
                wdata    <= 8'h00;
                rd_mode  <= 1'b0;
                nacked   <= 1'b0;
            end
        end
        else if (start_cond)
        begin
            state  <= EQASR_ST_ADDR;
            sda_oe <= 1'b0;
            count  <= 4'h0;
        end
        else if (scl_rise)
        begin
            case (state)
                EQASR_ST_ADDR, EQASR_ST_REG, EQASR_ST_WR:
                begin
                    shreg <= {shreg[6:0], sda_meta[1]};
                    count <= count + 4'h1;
                end
                EQASR_ST_RD:
                begin
                    shreg <= {shreg[6:0], 1'b0};
                    count <= count + 4'h1;
                end
                EQASR_ST_RACK:
                begin
                    nacked   <= sda_meta[1];
                    reg_addr <= reg_addr + 8'h01;
                end
                default:
                begin
                end
            endcase
        end
        else if (scl_fall)
        begin
            case (state)
                EQASR_ST_ADDR:
                    if (count == `EQASR_BYTE_LAST)
                    begin
                        if (shreg[7:1] == {`EQASR_DEV_ADDR_HI, strap_sync})
                        begin
                            sda_oe  <= 1'b1;
                            rd_mode <= shreg[0];
                            state   <= EQASR_ST_ACKA;
                        end
                        else
                            state <= EQASR_ST_IDLE;
                    end
                EQASR_ST_ACKA:
                begin
                    count <= 4'h0;
                    if (rd_mode)
                    begin
                        shreg     <= rdata;
                        sda_oe    <= ~rdata[7];
                        rd_strobe <= 1'b1;
                        state     <= EQASR_ST_RD;
                    end
                    else
                    begin
                        sda_oe <= 1'b0;
                        state  <= EQASR_ST_REG;
                    end
                end
                EQASR_ST_REG:
                    if (count == `EQASR_BYTE_LAST)
                    begin
                        sda_oe   <= 1'b1;
                        reg_addr <= shreg;
                        state    <= EQASR_ST_ACKR;
                    end
                EQASR_ST_ACKR, EQASR_ST_ACKW:
                begin
                    sda_oe <= 1'b0;
                    count  <= 4'h0;
                    state  <= EQASR_ST_WR;
                    if (state == EQASR_ST_ACKW)
                        reg_addr <= reg_addr + 8'h01;
                end
                EQASR_ST_WR:
                    if (count == `EQASR_BYTE_LAST)
                    begin
                        sda_oe    <= 1'b1;
                        wdata     <= shreg;
                        wr_strobe <= 1'b1;
                        state     <= EQASR_ST_ACKW;
                    end
                EQASR_ST_RD:
                    if (count == `EQASR_BYTE_LAST)
                    begin
                        sda_oe <= 1'b0;
                        state  <= EQASR_ST_RACK;
                    end
                    else
                        sda_oe <= ~shreg[7];
                EQASR_ST_RACK:
                begin
                    count <= 4'h0;
                    if (nacked)
                    begin
                        sda_oe <= 1'b0;
                        state  <= EQASR_ST_IDLE;
                    end
                    else
                    begin
                        shreg     <= rdata;
                        sda_oe    <= ~rdata[7];
                        rd_strobe <= 1'b1;
                        state     <= EQASR_ST_RD;
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

endmodule // eqasr_mgmt_slave

// ---- eqasr_pkg.sv ----
package eqasr_pkg;

    typedef enum logic [3:0] {
        EQASR_ST_IDLE = 4'h0,
        EQASR_ST_ADDR = 4'h1,
        EQASR_ST_ACKA = 4'h3,
        EQASR_ST_REG  = 4'h2,
        EQASR_ST_ACKR = 4'h6,
        EQASR_ST_WR   = 4'h7,
        EQASR_ST_ACKW = 4'h5,
        EQASR_ST_RD   = 4'h4,
        EQASR_ST_RACK = 4'hC
    } eqasr_mgmt_state_t;

    typedef logic [7:0] eqasr_byte_t;

endpackage

// ---- eqasr_properties.sv ----
`timescale 1ns/1ps
module eqasr_checker
(
    input wire logic       clk_sys,
    input wire logic       reset,
    input wire logic       scl_pin,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic [3:0] strap_pin,
    input wire logic [7:0] eye_opening,
    input wire logic       sig_det,
    input wire logic       cdr_lock,
    input wire logic       los_pin,
    input wire logic       eye_monitor_en,
    input wire logic       cdr_reset
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    property p_drive_low;
        sda_out == 1'h0;
    endproperty
    a_drive_low: assert property (p_drive_low)
        else $error("data pin drives a high level");
    property p_reset_clears;
        $past(reset) |-> !sda_oe && !los_pin && !cdr_reset && !eye_monitor_en;
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("outputs not cleared by reset");
    // Bus clock is seen through two flops, so the answer lags its fall
    property p_ack_timing;
        $rose(sda_oe) |-> !$past(scl_pin) && !$past(scl_pin, 2);
    endproperty
    a_ack_timing: assert property (p_ack_timing)
        else $error("data pulled low too soon after clock fall");
    property p_ack_stands;
        $rose(sda_oe) |-> sda_oe [*8];
    endproperty
    a_ack_stands: assert property (p_ack_stands)
        else $error("data pull released early");
    property p_cdr_on_ack;
        $changed(cdr_reset) |-> !$past(scl_pin);
    endproperty
    a_cdr_on_ack: assert property (p_cdr_on_ack)
        else $error("recovery reset moved outside a write");
    property p_monitor_staged;
        $changed(eye_monitor_en) |-> !cdr_reset && ($past(cdr_reset, 2)
            || $past(cdr_reset, 3) || $past(cdr_reset, 4));
    endproperty
    a_monitor_staged: assert property (p_monitor_staged)
        else $error("monitor enable moved without reset release");
    property p_los_rise;
        $rose(los_pin) |-> $past(sig_det) || eye_monitor_en
            || !$past(scl_pin) || $past(cdr_lock) != $past(cdr_lock, 4);
    endproperty
    a_los_rise: assert property (p_los_rise)
        else $error("loss pin rose without a cause");
    property p_los_fall;
        $fell(los_pin) |-> !$past(sig_det) || !$past(scl_pin);
    endproperty
    a_los_fall: assert property (p_los_fall)
        else $error("loss pin fell without a cause");
endmodule // eqasr_checker

bind eqasr_top eqasr_checker u_chk
(
    .clk_sys(clk_sys), .reset(reset), .scl_pin(scl_pin),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .strap_pin(strap_pin), .eye_opening(eye_opening),
    .sig_det(sig_det), .cdr_lock(cdr_lock), .los_pin(los_pin),
    .eye_monitor_en(eye_monitor_en), .cdr_reset(cdr_reset)
);

// ---- eqasr_top.sv ----
// Operation
// - The eye alert fires when the measured vertical opening drops below the threshold field times 4 steps of 3.125 mV.
// - Channel-control bit 5 routes the interrupt onto the loss-of-signal pin when 1, signal detect when 0, reset 0.
// - Shared register 0x00 bits 7:4 show the four address straps only while test control is above 9.
// - Writing 1 to bit 6 of shared register 0x04 returns all shared registers except channel control to defaults.
// - Channel-control bit 2 steers accesses to the channel set when 1 and the shared set when 0.
// - The interrupt status register holds the eye event in bit 3 and clears wholly on read.
`timescale 1ns/1ps
`include "eqasr_defines.svh"

module eqasr_top
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        scl_pin,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic [3:0]  strap_pin,
    input  wire logic [7:0]  eye_opening,
    input  wire logic        sig_det,
    input  wire logic        cdr_lock,
    output logic             los_pin,
    output logic             eye_monitor_en,
    output logic             cdr_reset
);
    import eqasr_pkg::*;

    logic [3:0]  strap_meta;
    logic [3:0]  strap_sync;
    eqasr_byte_t reg_addr;
    eqasr_byte_t wdata;
    eqasr_byte_t rdata;
    logic        wr_strobe;
    logic        rd_strobe;
    logic [3:0]  strap_obs_low;
    eqasr_byte_t soft_rst;
    eqasr_byte_t strap_en;
    eqasr_byte_t revision;
    eqasr_byte_t chan_ctrl;
    eqasr_byte_t cdr_ctrl;
    eqasr_byte_t eye_cfg;
    eqasr_byte_t thresh;
    eqasr_byte_t int_mask;
    eqasr_byte_t int_status;
    logic        act_eye_en;
    logic [3:0]  act_thresh;
    eqasr_byte_t act_mask;
    logic        cdr_rst_q;
    logic        eye_below;
    logic        eye_below_q;
    logic        sig_det_q;
    logic        cdr_lock_q;
    logic        chan_sel;
    logic        shared_wr;
    logic        chan_wr;
    logic        soft_rst_hit;
    logic        cdr_release;
    logic        strap_visible;
    eqasr_byte_t next_int_status;

    eqasr_mgmt_slave u_mgmt
    (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .scl_pin    (scl_pin),
        .sda_in     (sda_in),
        .strap_sync (strap_sync),
        .rdata      (rdata),
        .sda_oe     (sda_oe),
        .reg_addr   (reg_addr),
        .wdata      (wdata),
        .wr_strobe  (wr_strobe),
        .rd_strobe  (rd_strobe)
    );

    always_ff @(posedge clk_sys)
    begin
        strap_meta <= strap_pin;
        strap_sync <= strap_meta;
    end

    assign chan_sel      = chan_ctrl[`EQASR_BIT_CHAN_SEL];
    assign shared_wr     = wr_strobe & ~chan_sel;
    assign chan_wr       = wr_strobe & chan_sel;
    assign strap_visible = strap_en[3:0] > `EQASR_STRAP_EN_MIN;
    assign soft_rst_hit  = shared_wr && reg_addr == `EQASR_OFS_SOFT_RST
                           && wdata[`EQASR_BIT_SOFT_RST];

    // Shared set; a soft reset write lands the defaults, so bit 6 reads 0
    always_ff @(posedge clk_sys)
    begin
        if (reset || soft_rst_hit)
        begin
            strap_obs_low <= `EQASR_RST_STRAP_OBS;
            soft_rst      <= `EQASR_RST_SOFT_RST;
            strap_en      <= `EQASR_RST_STRAP_EN;
            revision      <= `EQASR_REVISION_CODE;
        end
        else if (shared_wr)
        begin
            if (reg_addr == `EQASR_OFS_STRAP_OBS)
                strap_obs_low <= wdata[3:0];
            else if (reg_addr == `EQASR_OFS_SOFT_RST)
                soft_rst <= wdata;
            else if (reg_addr == `EQASR_OFS_STRAP_EN)
                strap_en <= wdata;
            else if (reg_addr == `EQASR_OFS_REVISION)
                revision <= wdata;
        end
    end

    // Channel control is reachable from both sets
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            chan_ctrl <= `EQASR_RST_CHAN_CTRL;
        else if (wr_strobe && reg_addr == `EQASR_OFS_CHAN_CTRL)
            chan_ctrl <= wdata;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            cdr_ctrl <= `EQASR_RST_CDR_CTRL;
            eye_cfg  <= `EQASR_RST_EYE_CFG;
            thresh   <= `EQASR_RST_THRESH;
            int_mask <= `EQASR_RST_INT_MASK;
        end
        else if (chan_wr)
        begin
            if (reg_addr == `EQASR_OFS_CDR_CTRL)
                cdr_ctrl <= wdata;
            else if (reg_addr == `EQASR_OFS_EYE_CFG)
                eye_cfg <= wdata;
            else if (reg_addr == `EQASR_OFS_THRESH)
                thresh <= wdata;
            else if (reg_addr == `EQASR_OFS_INT_MASK)
                int_mask <= wdata;
        end
    end

    // Staged settings go live only as the recovery reset is released
    assign cdr_release = cdr_rst_q
        & ~(|cdr_ctrl[`EQASR_CDR_RST_HI:`EQASR_CDR_RST_LO]);

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            cdr_rst_q      <= 1'b0;
            act_eye_en     <= 1'b0;
            act_thresh     <= 4'h0;
            act_mask       <= `EQASR_RST_INT_MASK;
            eye_monitor_en <= 1'b0;
            cdr_reset      <= 1'b0;
        end
        else
        begin
            cdr_rst_q <= |cdr_ctrl[`EQASR_CDR_RST_HI:`EQASR_CDR_RST_LO];
            cdr_reset <= |cdr_ctrl[`EQASR_CDR_RST_HI:`EQASR_CDR_RST_LO];
            if (cdr_release)
            begin
                act_eye_en     <= ~eye_cfg[`EQASR_BIT_EYE_OFF];
                act_thresh     <= thresh[3:0];
                act_mask       <= int_mask;
                eye_monitor_en <= ~eye_cfg[`EQASR_BIT_EYE_OFF];
            end
        end
    end

    // Opening is in 3.125 mV steps, threshold field in steps of four
    assign eye_below = act_eye_en & ~cdr_rst_q
        & (eye_opening < {2'h0, act_thresh, 2'h0});

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            eye_below_q <= 1'b0;
            sig_det_q   <= 1'b0;
            cdr_lock_q  <= 1'b0;
        end
        else
        begin
            eye_below_q <= eye_below;
            sig_det_q   <= sig_det;
            cdr_lock_q  <= cdr_lock;
        end
    end

    // New events win over the clear from a read in the same cycle
    always_comb
    begin
        next_int_status = int_status;
        if (rd_strobe && chan_sel && reg_addr == `EQASR_OFS_INT_STATUS)
            next_int_status = 8'h00;
        if (eye_below && !eye_below_q)
            next_int_status[`EQASR_INT_EYE] = 1'b1;
        if (sig_det && !sig_det_q)
            next_int_status[`EQASR_INT_SIGDET] = 1'b1;
        if (cdr_lock && !cdr_lock_q)
            next_int_status[`EQASR_INT_LOCK] = 1'b1;
        if (!cdr_lock && cdr_lock_q)
            next_int_status[`EQASR_INT_LOCK_LOSS] = 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            int_status <= 8'h00;
            los_pin    <= 1'b0;
            sda_out    <= 1'b0;
        end
        else
        begin
            int_status <= next_int_status;
            if (chan_ctrl[`EQASR_BIT_ROUTE_INT])
                los_pin <= |(int_status & act_mask);
            else
                los_pin <= sig_det;
            sda_out <= 1'b0;
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb
    begin
        rdata = 8'h00;
        if (reg_addr == `EQASR_OFS_CHAN_CTRL)
            rdata = chan_ctrl;
        else if (!chan_sel && reg_addr == `EQASR_OFS_STRAP_OBS)
            rdata = {strap_visible ? strap_sync : 4'h0, strap_obs_low};
        else if (!chan_sel && reg_addr == `EQASR_OFS_SOFT_RST)
            rdata = soft_rst;
        else if (!chan_sel && reg_addr == `EQASR_OFS_STRAP_EN)
            rdata = strap_en;
        else if (!chan_sel && reg_addr == `EQASR_OFS_REVISION)
            rdata = revision;
        else if (chan_sel && reg_addr == `EQASR_OFS_CDR_CTRL)
            rdata = cdr_ctrl;
        else if (chan_sel && reg_addr == `EQASR_OFS_EYE_CFG)
            rdata = eye_cfg;
        else if (chan_sel && reg_addr == `EQASR_OFS_THRESH)
            rdata = thresh;
        else if (chan_sel && reg_addr == `EQASR_OFS_INT_STATUS)
            rdata = int_status;
        else if (chan_sel && reg_addr == `EQASR_OFS_INT_MASK)
            rdata = int_mask;
    end

endmodule // eqasr_top

// ---- eye_quality_alert_and_shared_regs_test.sv ----
`timescale 1ns/1ps
`include "eqasr_defines.svh"
module eye_quality_alert_and_shared_regs_test;
    logic       clk_sys     = 1'h0;
    logic       reset       = 1'h1;
    logic [3:0] strap_pin   = 4'hA;
    logic [7:0] eye_opening = 8'hFF;
    logic       sig_det     = 1'h0;
    logic       cdr_lock    = 1'h0;
    logic       scl_pin, sda_low, sda_out, sda_oe, sda_wire;
    logic       los_pin, eye_monitor_en, cdr_reset;
    logic [7:0] rd;
    int         n_mismatch  = 0;
    int         n_checks    = 0;
    localparam logic [6:0] ADDR = {`EQASR_DEV_ADDR_HI, 4'hA};

    // Pulled-up open-drain data line
    assign sda_wire = ~(sda_low | sda_oe);

    eqasr_top uut
    (
        .clk_sys(clk_sys), .reset(reset), .scl_pin(scl_pin),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .strap_pin(strap_pin), .eye_opening(eye_opening),
        .sig_det(sig_det), .cdr_lock(cdr_lock), .los_pin(los_pin),
        .eye_monitor_en(eye_monitor_en), .cdr_reset(cdr_reset)
    );
    eqasr_host_model host
    (
        .clk_sys(clk_sys), .dev_addr(ADDR), .sda_wire(sda_wire),
        .scl_pin(scl_pin), .sda_low(sda_low)
    );

    initial
        forever #12.5 clk_sys = ~clk_sys;

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] ofs, input logic [7:0] exp);
        host.rd_reg(ofs, rd);
        chk8(rd, exp);
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        host.wr_reg(ADDR, ofs, d, 1'h0);
    endtask

    task automatic t_shared();
        rdchk(`EQASR_OFS_REVISION, `EQASR_REVISION_CODE);
        rdchk(`EQASR_OFS_SOFT_RST, 8'h01);
        rdchk(`EQASR_OFS_CHAN_CTRL, 8'h00);
        rdchk(`EQASR_OFS_STRAP_OBS, 8'h00);
        wr(`EQASR_OFS_STRAP_EN, 8'h09);
        rdchk(`EQASR_OFS_STRAP_OBS, 8'h00);
        wr(`EQASR_OFS_STRAP_EN, 8'h0A);
        wr(`EQASR_OFS_STRAP_OBS, 8'hF3);
        rdchk(`EQASR_OFS_STRAP_OBS, 8'hA3);
        rdchk(`EQASR_OFS_EYE_CFG, 8'h00);
        wr(`EQASR_OFS_SOFT_RST, 8'h40);
        rdchk(`EQASR_OFS_STRAP_EN, 8'h00);
        rdchk(`EQASR_OFS_STRAP_OBS, 8'h00);
        rdchk(`EQASR_OFS_SOFT_RST, 8'h01);
        host.wr_reg(7'h00, `EQASR_OFS_STRAP_EN, 8'h0F, 1'h0);
        chk8(8'(host.nack_cnt), 8'h01);
        rdchk(`EQASR_OFS_STRAP_EN, 8'h00);
    endtask

    task automatic t_route();
        sig_det <= 1'h1;
        host.tick(4);
        chk8({7'h00, los_pin}, 8'h01);
        sig_det <= 1'h0;
        host.tick(4);
        chk8({7'h00, los_pin}, 8'h00);
    endtask

    // Host order: shared first, then channel set, then a recovery reset pulse
    task automatic t_eye();
        eye_opening <= 8'h18;
        wr(`EQASR_OFS_CHAN_CTRL, 8'h04);
        // Signal-detect rise from the routing scenario is still latched
        rdchk(`EQASR_OFS_INT_STATUS, 8'h80);
        rdchk(`EQASR_OFS_EYE_CFG, 8'h20);
        wr(`EQASR_OFS_EYE_CFG, 8'h00);
        wr(`EQASR_OFS_THRESH, 8'h06);
        wr(`EQASR_OFS_INT_MASK, 8'h08);
        wr(`EQASR_OFS_CHAN_CTRL, 8'h24);
        chk8({7'h00, eye_monitor_en}, 8'h00);
        wr(`EQASR_OFS_CDR_CTRL, 8'h0C);
        chk8({7'h00, cdr_reset}, 8'h01);
        wr(`EQASR_OFS_CDR_CTRL, 8'h00);
        chk8({7'h00, eye_monitor_en}, 8'h01);
        chk8({7'h00, cdr_reset}, 8'h00);
        chk8({7'h00, los_pin}, 8'h00);
        eye_opening <= 8'h17;
        host.tick(6);
        chk8({7'h00, los_pin}, 8'h01);
        rdchk(`EQASR_OFS_INT_STATUS, 8'h08);
        chk8({7'h00, los_pin}, 8'h00);
        rdchk(`EQASR_OFS_INT_STATUS, 8'h00);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(posedge clk_sys);
        reset <= 1'h0;
        host.tick(4);
        t_shared();
        t_route();
        t_eye();
        stop_test();
    end

    // A whole run is near 15k cycles; the limit leaves ample room
    initial
    begin
        repeat (40000) @(posedge clk_sys);
        n_mismatch++;
        stop_test();
    end
endmodule // eye_quality_alert_and_shared_regs_test
